// ---- design/press_supervisor_defines.vh ----
// Functional notes
// RQ1 - Operator pairs each station's palms within half second
// RQ2 - All palms within five seconds or no stroke
// RQ3 - Multi-station option checks only the concurrent window
// RQ4 - Station select limits which palms start strokes
// RQ5 - Any detected problem stops press, shows fault
// RQ6 - Fault shown as class letter plus two digits
// RQ7 - Class E latched until power cycle only
// RQ8 - Class F cleared by reset button
// RQ9 - Class H cleared by reset button
// RQ10 - Remote reset clears F and H too
// RQ11 - Clearing lockout fault shows lockout message
// RQ12 - Lockout clears after selector OFF then other
// RQ13 - Flash brake warning within 10 ms of limit
// RQ14 - Brake warning latched until power cycle
// RQ15 - Stop time over limit: flash value, inhibit
// RQ16 - Rerun unrepaired brake: stop, fault shown again
// RQ17 - Stop-time fault reset clears, then lockout
// RQ18 - Resolver fault on overspeed or lost angle
// RQ19 - Ram moved with valve de-energized raises fault
// RQ20 - Palms on unselected station raise fault; not raised when station select is 0
// RQ21 - Missed window needs full release before retry
`ifndef PRESS_SUPERVISOR_DEFINES_VH
`define PRESS_SUPERVISOR_DEFINES_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ            10000000
`define PALM_TIME_MS      500
`define CONC_TIME_MS      5000
`define BLINK_HALF_MS     250
`define WARN_MARGIN_MS    16'h000a
`define OVERSPEED_SPM     11'h3e8

// ------------------------------------------------------------
// Register offsets and fields
// ------------------------------------------------------------
`define REG_STOP_LIMIT    4'h0
`define REG_STOP_TIME     4'h4
`define REG_STATUS        4'h8
`define REG_FAULT_POST    4'hc
`define POST_NUM_LSB      0
`define POST_NUM_MSB      7
`define POST_CLASS_LSB    8
`define POST_CLASS_MSB    9
`define POST_LOCK_BIT     10
`define STOP_LIMIT_RST    16'h00c8

// ------------------------------------------------------------
// Fault classes and codes (numbers are BCD)
// ------------------------------------------------------------
`define CLASS_NONE        2'h0
`define CLASS_E           2'h1
`define CLASS_F           2'h2
`define CLASS_H           2'h3
`define CODE_RESOLVER     8'h04
`define CODE_RAM_MOVED    8'h11
`define CODE_UNSEL_STN    8'h24

// ------------------------------------------------------------
// Selector encodings
// ------------------------------------------------------------
`define STROKE_OFF        2'h0
`define STN_A             2'h1
`define STN_B             2'h2
`define STN_BOTH          2'h3
`define PIN_IDLE          15'h0002 // Synced pins at rest: angle sensor good

`endif

// ---- design/window_timer.v ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Window timer: flags when a run lasts LIMIT cycles
// ------------------------------------------------------------
module window_timer #(
  parameter WIDTH = 26,
  parameter LIMIT = 26'h1
) (
  input  wire clk_sys,
  input  wire rst,
  input  wire clr,
  input  wire run,
  output wire expired
);
  reg [WIDTH-1:0] count_q; // Cycles spent running since clear

  assign expired = (count_q >= LIMIT);

  // Count saturates at the limit so it never wraps back
  always @(posedge clk_sys) begin
    if (rst || clr) begin
      count_q <= {WIDTH{1'b0}};
    end else if (run && !expired) begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ---- design/press_fault_and_palm_supervisor.v ----
`timescale 1ns/1ps
`include "press_supervisor_defines.vh"
module press_fault_and_palm_supervisor #(
  parameter PALM_CYCLES  = 26'd5000000,
  parameter CONC_CYCLES  = 26'd50000000,
  parameter BLINK_CYCLES = 26'd2500000
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [1:0]  palm_a,
  input  wire [1:0]  palm_b,
  input  wire [1:0]  station_select,
  input  wire        multi_station_opt,
  input  wire [1:0]  stroke_sel,
  input  wire        reset_button,
  input  wire        remote_reset,
  input  wire        ram_moving,
  input  wire        dual_safety_valve_on,
  input  wire        angle_valid,
  input  wire [10:0] speed_spm,
  input  wire [15:0] stop_time_ms,
  input  wire        stop_time_valid,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output wire        stop_cmd,
  output wire        stroke_go,
  output wire [1:0]  disp_class,
  output wire [7:0]  disp_num,
  output wire        disp_lockout,
  output wire [15:0] disp_stop_time,
  output wire        disp_flash,
  output wire        brake_warn_led
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam PINS = 15;
  wire [PINS-1:0] pin_raw;   // Raw pins from switches and sensors
  reg  [PINS-1:0] pin_s1_q;  // First stage, read only by second
  reg  [PINS-1:0] pin_s2_q;  // Safe to use from here on

  assign pin_raw = {palm_a, palm_b, station_select, multi_station_opt, stroke_sel,
                    reset_button, remote_reset, ram_moving, dual_safety_valve_on,
                    angle_valid, 1'b0};

  // Two flops per pin; idle reset so no false angle loss follows reset
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_q <= `PIN_IDLE;
      pin_s2_q <= `PIN_IDLE;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire [1:0] pa     = pin_s2_q[14:13]; // Station A palms
  wire [1:0] pb     = pin_s2_q[12:11]; // Station B palms
  wire [1:0] sel    = pin_s2_q[10:9];  // Station select
  wire       multi  = pin_s2_q[8];     // Multi-station option
  wire [1:0] stroke = pin_s2_q[7:6];   // Stroke selector
  wire       rbtn   = pin_s2_q[5];     // Front reset
  wire       rrem   = pin_s2_q[4];     // Remote reset
  wire       ram_mv = pin_s2_q[3];     // Ram motion seen
  wire       dsv_on = pin_s2_q[2];     // Valve drive energised
  wire       ang_ok = pin_s2_q[1];     // Angle sensor good

  reg  reset_any_q;                    // Previous reset level
  wire reset_any  = rbtn | rrem;       // RQ10
  wire reset_edge = reset_any & ~reset_any_q;

  // ------------------------------------------------------------
  // Registers seen by software
  // ------------------------------------------------------------
  reg [15:0] stop_limit_q;   // Stop-time limit in ms
  reg [15:0] stop_last_q;    // Last measured stop time
  reg        post_q;         // One-cycle fault post from software
  reg [10:0] post_data_q;    // Posted class, number, lockout flag

  // Writes steer the limit and post processor faults
  always @(posedge clk_sys) begin
    if (rst) begin
      stop_limit_q <= `STOP_LIMIT_RST;
      post_q       <= 1'b0;
      post_data_q  <= 11'h000;
    end else begin
      post_q <= 1'b0;
      if (reg_wr && reg_addr == `REG_STOP_LIMIT) begin
        stop_limit_q <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `REG_FAULT_POST) begin
        post_q      <= 1'b1;
        post_data_q <= reg_wdata[`POST_LOCK_BIT:`POST_NUM_LSB];
      end
    end
  end

  // ------------------------------------------------------------
  // Palm window checks
  // ------------------------------------------------------------
  localparam S_WAIT_REL = 2'h0;
  localparam S_READY    = 2'h1;
  localparam S_ARM      = 2'h2;
  localparam S_RUN      = 2'h3;
  reg  [1:0] state_q;        // Palm sequencer state
  reg  [1:0] state_d;

  wire sel_a = sel[0];                          // RQ4
  wire sel_b = sel[1];                          // RQ4
  wire [3:0] live  = {pa & {2{sel_a}}, pb & {2{sel_b}}};
  wire need_all    = (sel != 2'h0);
  wire all_held    = need_all & (!sel_a | (&pa)) & (!sel_b | (&pb));
  wire any_held    = |live;
  wire all_free    = ~(|pa) & ~(|pb);
  wire timers_clr  = (state_q != S_ARM);
  // Per-station pairing only when the option is off
  wire pair_a_run  = !multi & sel_a & (|pa) & !(&pa); // RQ3
  wire pair_b_run  = !multi & sel_b & (|pb) & !(&pb); // RQ3
  wire miss_a;
  wire miss_b;
  wire miss_conc;
  wire inhibit;
  wire window_miss = miss_a | miss_b | miss_conc;

  window_timer #(.WIDTH(26), .LIMIT(PALM_CYCLES)) u_pair_a (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (timers_clr),
    .run     (pair_a_run),
    .expired (miss_a)
  );

  window_timer #(.WIDTH(26), .LIMIT(PALM_CYCLES)) u_pair_b (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (timers_clr),
    .run     (pair_b_run),
    .expired (miss_b)
  );

  // Concurrent window across every selected station
  window_timer #(.WIDTH(26), .LIMIT(CONC_CYCLES)) u_conc (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (timers_clr),
    .run     (!all_held),
    .expired (miss_conc)
  );

  // Sequencer: release, first press, all held, run
  always @* begin
    state_d = state_q;
    case (state_q)
      S_WAIT_REL: begin
        if (all_free) begin
          state_d = S_READY;                    // RQ21
        end
      end
      S_READY: begin
        if (any_held && !inhibit) begin
          state_d = S_ARM;
        end
      end
      S_ARM: begin
        if (inhibit || window_miss) begin
          state_d = S_WAIT_REL;                 // RQ21
        end else if (all_held) begin
          state_d = S_RUN;                      // RQ2
        end else if (!any_held) begin
          state_d = S_READY;
        end
      end
      S_RUN: begin
        // Any release or stop ends the stroke permit
        if (inhibit || !all_held) begin
          state_d = S_WAIT_REL;
        end
      end
      default: begin
        state_d = S_WAIT_REL;
      end
    endcase
  end

  // State flop
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= S_WAIT_REL;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // Fault detectors
  // ------------------------------------------------------------
  wire f_ram   = ram_mv & !dsv_on;                            // RQ19
  wire f_res   = (speed_spm > `OVERSPEED_SPM) | !ang_ok;      // RQ18
  wire f_unsel = ((sel != `STN_BOTH) && need_all) &&
                 ((!sel_a && (|pa)) || (!sel_b && (|pb)));    // RQ20

  reg       raise;          // Some detector or a software post fires this cycle
  reg [1:0] raise_class;
  reg [7:0] raise_num;
  reg       raise_lock;

  // Fixed priority among detectors; ram motion is the worst
  always @* begin
    raise       = 1'b1;
    raise_class = `CLASS_F;
    raise_num   = `CODE_RAM_MOVED;
    raise_lock  = 1'b1;
    if (f_ram) begin
      raise_num = `CODE_RAM_MOVED;
    end else if (f_res) begin
      raise_num  = `CODE_RESOLVER;
      raise_lock = 1'b0;
    end else if (f_unsel) begin
      raise_num  = `CODE_UNSEL_STN;
      raise_lock = 1'b0;
    end else if (post_q) begin
      raise_class = post_data_q[`POST_CLASS_MSB:`POST_CLASS_LSB];
      raise_num   = post_data_q[`POST_NUM_MSB:`POST_NUM_LSB];
      raise_lock  = post_data_q[`POST_LOCK_BIT];
    end else begin
      raise      = 1'b0;
      raise_lock = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Fault latch, lockout and brake monitor
  // ------------------------------------------------------------
  reg        flt_q;          // A coded fault is latched
  reg [1:0]  flt_class_q;
  reg [7:0]  flt_num_q;
  reg        flt_lock_q;
  reg        stt_q;          // Stop-time exceeded
  reg [15:0] stt_val_q;      // Stop time being flashed
  reg        lock_q;         // Lockout message showing
  reg        lock_off_q;     // Selector seen at OFF during lockout
  reg        warn_q;         // Brake warning latched

  wire clr_ok  = (flt_class_q == `CLASS_F) || (flt_class_q == `CLASS_H); // RQ7
  wire clr_flt = reset_edge & flt_q & clr_ok;                            // RQ8 RQ9
  wire [16:0] warn_sum = {1'b0, stop_time_ms} + {1'b0, `WARN_MARGIN_MS};
  wire over  = stop_time_valid && (stop_time_ms > stop_limit_q);         // RQ16
  wire close = stop_time_valid && (warn_sum >= {1'b0, stop_limit_q});

  // A new fault beats a clear in the same cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      flt_q       <= 1'b0;
      flt_class_q <= `CLASS_NONE;
      flt_num_q   <= 8'h00;
      flt_lock_q  <= 1'b0;
    end else if (raise && (!flt_q || clr_flt)) begin
      flt_q       <= 1'b1;                      // RQ5
      flt_class_q <= raise_class;               // RQ6
      flt_num_q   <= raise_num;
      flt_lock_q  <= raise_lock;
    end else if (clr_flt) begin
      flt_q       <= 1'b0;                      // RQ8 RQ9
      flt_class_q <= `CLASS_NONE;
      flt_num_q   <= 8'h00;
      flt_lock_q  <= 1'b0;
    end
  end

  // Stop-time fault: repeat runs set it again until fixed
  always @(posedge clk_sys) begin
    if (rst) begin
      stt_q       <= 1'b0;
      stt_val_q   <= 16'h0000;
      stop_last_q <= 16'h0000;
    end else begin
      if (stop_time_valid) begin
        stop_last_q <= stop_time_ms;
      end
      if (over) begin
        stt_q     <= 1'b1;                      // RQ15 RQ16
        stt_val_q <= stop_time_ms;
      end else if (reset_edge) begin
        stt_q <= 1'b0;                          // RQ17
      end
    end
  end

  // Brake warning only a power cycle removes
  always @(posedge clk_sys) begin
    if (rst) begin
      warn_q <= 1'b0;
    end else if (close) begin
      warn_q <= 1'b1;                           // RQ13 RQ14
    end
  end

  // Lockout: set on clearing a lockout fault, leave via OFF
  always @(posedge clk_sys) begin
    if (rst) begin
      lock_q      <= 1'b0;
      lock_off_q  <= 1'b0;
      reset_any_q <= 1'b0;
    end else begin
      reset_any_q <= reset_any;
      if ((clr_flt && flt_lock_q) || (reset_edge && stt_q && !over)) begin
        lock_q     <= 1'b1;                     // RQ11 RQ17
        lock_off_q <= 1'b0;
      end else if (lock_q && stroke == `STROKE_OFF) begin
        lock_off_q <= 1'b1;                     // RQ12
      end else if (lock_q && lock_off_q) begin
        lock_q     <= 1'b0;                     // RQ12
        lock_off_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Flash clock and outputs
  // ------------------------------------------------------------
  reg [25:0] blink_cnt_q;    // Half-period counter
  reg        blink_q;        // Flash phase

  // Slow square wave shared by every flashing indicator
  always @(posedge clk_sys) begin
    if (rst) begin
      blink_cnt_q <= 26'h0000000;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q >= BLINK_CYCLES - 26'd1) begin
      blink_cnt_q <= 26'h0000000;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 26'd1;
    end
  end

  // Stop and inhibit are combined: any one keeps the press still
  assign inhibit        = flt_q | stt_q | lock_q;       // RQ12 RQ15
  assign stop_cmd       = inhibit;                      // RQ5
  assign stroke_go      = (state_q == S_RUN);
  assign disp_class     = flt_class_q;                  // RQ6
  assign disp_num       = flt_num_q;
  assign disp_lockout   = lock_q & !flt_q;              // RQ11
  assign disp_stop_time = stt_val_q;
  assign disp_flash     = stt_q & blink_q;              // RQ15
  assign brake_warn_led = warn_q & blink_q;             // RQ13

  // ------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_STOP_LIMIT: reg_rdata <= {16'h0000, stop_limit_q};
        `REG_STOP_TIME:  reg_rdata <= {16'h0000, stop_last_q};
        `REG_STATUS:     reg_rdata <= {16'h0000, state_q, warn_q, lock_q, stt_q,
                                       flt_lock_q, flt_q, flt_class_q == `CLASS_NONE,
                                       flt_class_q == `CLASS_E ? flt_num_q : flt_num_q};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// ---- testbench/press_supervisor_props.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Output checks of the supervisor
// ------------------------------------------------------------
module press_supervisor_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic        ram_moving,
  input wire logic        dual_safety_valve_on,
  input wire logic [10:0] speed_spm,
  input wire logic [31:0] reg_rdata,
  input wire logic        stop_cmd,
  input wire logic        stroke_go,
  input wire logic [1:0]  disp_class,
  input wire logic        disp_lockout,
  input wire logic        disp_flash,
  input wire logic        brake_warn_led
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A held stop leaves no stroke running
  go_under_stop_a: assert property (stop_cmd [*2] |-> !stroke_go)
    else $error("stroke permitted while stopped");
  // Two cycles allowed for display and stop flops to agree
  fault_stops_a: assert property ((disp_class != 2'h0) [*2] |-> stop_cmd)
    else $error("fault shown without stop");
  // Class E survives any button
  e_latched_a: assert property (disp_class == 2'h1 |=> disp_class == 2'h1)
    else $error("class E fault cleared without power cycle");
  // Two sync stages, then the fault latch
  ram_moved_a: assert property (
    (ram_moving && !dual_safety_valve_on) [*4] |-> ##[0:4] (stop_cmd && disp_class != 2'h0))
    else $error("ram motion with valve off not faulted");
  // Speed is same-clock, so a shorter bound
  overspeed_a: assert property (
    (speed_spm > 11'h3e8) [*2] |-> ##[0:3] (stop_cmd && disp_class != 2'h0))
    else $error("overspeed not faulted");
  // Read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  // Lockout message refuses to run and hides behind coded faults
  lockout_stop_a: assert property (disp_lockout |-> stop_cmd && disp_class == 2'h0)
    else $error("lockout shown without stop");
  // Flashing stop time means the press is inhibited
  flash_stop_a: assert property (disp_flash |-> stop_cmd)
    else $error("stop time flashing without inhibit");
  // Warning keeps blinking once it is latched
  warn_hold_a: assert property ($fell(brake_warn_led) |-> ##[1:12] brake_warn_led)
    else $error("brake warning stopped blinking");
endmodule

bind press_fault_and_palm_supervisor press_supervisor_props props_u (
  .clk_sys, .rst, .reg_rd, .ram_moving, .dual_safety_valve_on, .speed_spm, .reg_rdata,
  .stop_cmd, .stroke_go, .disp_class, .disp_lockout, .disp_flash, .brake_warn_led
);

// ---- testbench/press_field_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Operator stations and stop-time sensor
// ------------------------------------------------------------
module press_field_model (
  input  wire logic        clk_sys,
  output logic      [1:0]  palm_a,
  output logic      [1:0]  palm_b,
  output logic      [15:0] stop_time_ms,
  output logic             stop_time_valid
);
  // Released switches read open
  initial begin
    palm_a = 2'h0;
    palm_b = 2'h0;
    stop_time_ms = 16'h0;
    stop_time_valid = 1'b0;
  end

  // Operator closes one station's pair; gap sets how late the second hand is
  task automatic press_pair(input bit stn_b, input int gap);
    @(posedge clk_sys);
    if (stn_b) palm_b[0] <= 1'b1;
    else palm_a[0] <= 1'b1;
    repeat (gap + 1) @(posedge clk_sys);
    if (stn_b) palm_b[1] <= 1'b1;
    else palm_a[1] <= 1'b1;
  endtask

  // Both hands off, long enough for the sequencer to re-arm
  task automatic release_all();
    @(posedge clk_sys);
    palm_a <= 2'h0;
    palm_b <= 2'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  // One measurement; the bus is scrambled after so stale data is not trusted
  task automatic measure(input logic [15:0] t);
    @(posedge clk_sys);
    stop_time_ms <= t;
    stop_time_valid <= 1'b1;
    @(posedge clk_sys);
    stop_time_valid <= 1'b0;
    stop_time_ms <= ~t;
  endtask
endmodule

// ---- testbench/press_fault_and_palm_supervisor_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got %h expected %h", $time, got, exp); end end
module press_fault_and_palm_supervisor_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [4:0] LK = 5'h01, ST = 5'h02, GO = 5'h04, WN = 5'h08, FL = 5'h10;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  palm_a, palm_b, station_select, stroke_sel, disp_class;
  logic        multi_station_opt, reset_button, remote_reset, ram_moving;
  logic        dual_safety_valve_on, angle_valid, stop_time_valid, reg_wr, reg_rd;
  logic [10:0] speed_spm;
  logic [15:0] stop_time_ms, disp_stop_time;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, got, rng, want;
  logic [15:0] st_exp = 16'h0000; // Stop time expected on the display
  logic [7:0]  disp_num;
  logic        stop_cmd, stroke_go, disp_lockout, disp_flash, brake_warn_led;
  logic        chk = 1'b0;
  logic        rd_q = 1'b0;
  logic        warn_seen, flash_seen;
  logic [31:0] exp_q[$];          // Expected results, oldest first
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  // Short windows keep the run small
  press_fault_and_palm_supervisor #(.PALM_CYCLES(26'd20), .CONC_CYCLES(26'd200),
    .BLINK_CYCLES(26'd4)) dut_u (
    .clk_sys, .rst, .palm_a, .palm_b, .station_select, .multi_station_opt, .stroke_sel,
    .reset_button, .remote_reset, .ram_moving, .dual_safety_valve_on, .angle_valid,
    .speed_spm, .stop_time_ms, .stop_time_valid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .stop_cmd, .stroke_go, .disp_class, .disp_num, .disp_lockout,
    .disp_stop_time, .disp_flash, .brake_warn_led);
  press_field_model field_u (.clk_sys, .palm_a, .palm_b, .stop_time_ms, .stop_time_valid);

  initial forever #50 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Watcher: blink seen flags, compares oldest note on each result
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      warn_seen <= 1'b0;
      flash_seen <= 1'b0;
    end else begin
      warn_seen <= brake_warn_led | (warn_seen & ~chk);
      flash_seen <= disp_flash | (flash_seen & ~chk);
    end
    rd_q <= reg_rd;
    if (rd_q || chk) begin
      got = rd_q ? reg_rdata : {1'b0, disp_stop_time, flash_seen, warn_seen, stroke_go,
        stop_cmd, disp_lockout, disp_class, disp_num};
      want = exp_q.pop_front();
      `CHK(got, want)
    end
  end

  // Hang guard, far above the roughly 850 cycles needed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // Let syncs and blink settle, then ask for a snapshot compare
  task automatic look(input logic [4:0] f, input logic [1:0] c, input logic [7:0] n);
    repeat (10) @(posedge clk_sys);
    exp_q.push_back({1'b0, st_exp, f, c, n});
    chk <= 1'b1;
    @(posedge clk_sys);
    chk <= 1'b0;
  endtask

  task automatic push(input bit remote);
    @(posedge clk_sys);
    if (remote) remote_reset <= 1'b1;
    else reset_button <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset_button <= 1'b0;
    remote_reset <= 1'b0;
  endtask

  // Selector through OFF and back to a stroke position
  task automatic sel(input logic [1:0] s);
    @(posedge clk_sys);
    stroke_sel <= 2'h0;
    repeat (4) @(posedge clk_sys);
    stroke_sel <= s;
  endtask

  task automatic both(input int g);
    field_u.press_pair(1'b0, g);
    field_u.press_pair(1'b1, g);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rng = 32'he9110371;
    station_select = 2'h3;
    stroke_sel = 2'h1;
    multi_station_opt = 1'b0;
    reset_button = 1'b0;
    remote_reset = 1'b0;
    ram_moving = 1'b0;
    dual_safety_valve_on = 1'b0;
    angle_valid = 1'b1;
    speed_spm = 11'h064;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 32'h00c8);
    rd(4'h8, 32'h4100);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'h1234);
    rd(4'h4, 32'h0);
    wr(4'h0, 32'h0064);
    rd(4'h0, 32'h0064);
    both(int'(xs() % 8));
    look(GO, 2'h0, 8'h0);
    field_u.release_all();
    field_u.press_pair(1'b0, 30);
    field_u.press_pair(1'b1, 0);
    look(5'h0, 2'h0, 8'h0);
    field_u.release_all();
    field_u.press_pair(1'b0, 0);
    repeat (250) @(posedge clk_sys);
    field_u.press_pair(1'b1, 0);
    look(5'h0, 2'h0, 8'h0);
    field_u.release_all();
    multi_station_opt <= 1'b1;
    field_u.press_pair(1'b0, 0);
    field_u.press_pair(1'b1, 30);
    look(GO, 2'h0, 8'h0);
    field_u.release_all();
    multi_station_opt <= 1'b0;
    station_select <= 2'h1;
    field_u.press_pair(1'b0, 0);
    look(GO, 2'h0, 8'h0);
    field_u.release_all();
    field_u.press_pair(1'b1, 0);
    look(ST, 2'h2, 8'h24);
    field_u.release_all();
    push(1'b0);
    look(5'h0, 2'h0, 8'h0);
    station_select <= 2'h3;
    for (int i = 0; i < 2; i++) begin
      wr(4'hc, {22'h0, 2'h2 + 2'(i), i ? 8'h38 : 8'h33});
      look(ST, 2'h2 + 2'(i), i ? 8'h38 : 8'h33);
      push(i[0]);
      look(5'h0, 2'h0, 8'h0);
    end
    dual_safety_valve_on <= 1'b1;
    ram_moving <= 1'b1;
    look(5'h0, 2'h0, 8'h0);
    dual_safety_valve_on <= 1'b0;
    look(ST, 2'h2, 8'h11);
    ram_moving <= 1'b0;
    push(1'b0);
    look(ST | LK, 2'h0, 8'h0);
    both(0);
    look(ST | LK, 2'h0, 8'h0);
    field_u.release_all();
    sel(2'h1);
    look(5'h0, 2'h0, 8'h0);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) speed_spm <= 11'd1001 + 11'(xs() % 1000);
      else angle_valid <= 1'b0;
      look(ST, 2'h2, 8'h04);
      speed_spm <= 11'h064;
      angle_valid <= 1'b1;
      push(1'b0);
      look(5'h0, 2'h0, 8'h0);
    end
    field_u.measure(16'd90);
    look(WN, 2'h0, 8'h0);
    st_exp = 16'd112;
    for (int i = 0; i < 2; i++) begin
      field_u.measure(16'd112);
      look(ST | WN | FL, 2'h0, 8'h0);
      rd(4'h4, 32'd112);
      push(1'b0);
      look(ST | WN | FL | LK, 2'h0, 8'h0);
      sel(2'h2);
      look(WN, 2'h0, 8'h0);
    end
    wr(4'hc, 32'h0107);
    look(ST | WN, 2'h1, 8'h07);
    push(1'b0);
    look(ST | WN, 2'h1, 8'h07);
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    st_exp = 16'h0000;
    look(5'h0, 2'h0, 8'h0);
    final_report();
  end
endmodule
